/* File: scc_phase_gen.sv */
`timescale 1ns/1ps
module scc_phase_gen
    import scc_pkg::*;
#(
    parameter int PERIOD = SCC_PERIOD_DIV
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ref_clk_i,
    input  wire logic       ref_sel_i,
    scc_phase_if.gen        ph
);
    localparam int DELAY = (PERIOD * SCC_PHASE_DEG) / 360;

    initial begin
        if (PERIOD < 3 || (PERIOD * SCC_PHASE_DEG) % 360 != 0) begin
            $error("period must be at least 3 and split into thirds");
        end
    end

    logic [7:0] cnt_q;
    logic [7:0] dly_q;
    logic       ref_q;
    logic       run_q;
    logic       lost_q;
    logic [7:0] gap_q;
    wire  logic ref_edge = ref_sel_i & ph.tick & ~ref_q;
    wire  logic wrap     = (cnt_q == 8'(PERIOD - 1));
    wire  logic period_start = ref_sel_i ? (ref_edge | (lost_q & wrap)) : wrap;

    // free-running fallback keeps switching if the chained clock dies
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 8'h00;
            ref_q  <= 1'b0;
            gap_q  <= 8'h00;
            lost_q <= 1'b0;
        end else begin
            ref_q  <= ph.tick;
            cnt_q  <= (period_start | wrap) ? 8'h00 : cnt_q + 8'h01;
            gap_q  <= ref_edge ? 8'h00 : ((gap_q == 8'hFF) ? gap_q : gap_q + 8'h01);
            lost_q <= ref_sel_i & (gap_q > 8'(2 * PERIOD));
        end
    end

    // delay line puts our edge a third of a period after the reference
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dly_q <= 8'h00;
            run_q <= 1'b0;
        end else if (period_start) begin
            dly_q <= 8'h00;
            run_q <= 1'b1;
        end else if (run_q) begin
            dly_q <= dly_q + 8'h01;
            run_q <= (dly_q != 8'(DELAY - 1));
        end
    end

    assign ph.phase_pulse = run_q & (dly_q == 8'(DELAY - 1));
    assign ph.sync_lost   = lost_q;

    property p_phase_gap;
        @(posedge sys_clk_i) disable iff (rst_i)
        period_start |-> ##DELAY ph.phase_pulse;
    endproperty
    a_phase_gap: assert property (p_phase_gap) else $error("phase offset wrong");
endmodule

/* File: scc_phase_if.sv */
`timescale 1ns/1ps
interface scc_phase_if;
    logic       tick;
    logic       phase_pulse;
    logic       sync_lost;
    modport gen  (input tick, output phase_pulse, output sync_lost);
    modport ctrl (output tick, input phase_pulse, input sync_lost);
endinterface

/* File: scc_pkg.sv */
package scc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int          SCC_CLK_HZ        = 40_000_000;
    localparam int          SCC_INIT_US       = 400;
    localparam int          SCC_INIT_CYCLES   = SCC_INIT_US * (SCC_CLK_HZ / 1_000_000);
    localparam int          SCC_PHASE_DEG     = 120;
    localparam int          SCC_PERIOD_DIV    = 18;
    localparam int          SCC_RAMP_CYCLES   = 64;

    // ****************************************
    // reset values and settings
    // ****************************************
    localparam logic        SCC_ROLE_RST      = 1'b0;
    localparam logic [1:0]  SCC_VSEL_RST      = 2'h0;
    localparam logic        SCC_STRAP_SECOND  = 1'b0;

    typedef enum logic [2:0] {
        SCC_ST_INIT,
        SCC_ST_WAIT_EN,
        SCC_ST_RAMP,
        SCC_ST_RUN,
        SCC_ST_FAULT
    } scc_state_t;

endpackage

/* File: scc_stack_ctrl.sv */
`timescale 1ns/1ps

// Overview of operation
// - resistor on sync out selects secondary
// - floating sync out selects primary
// - pull enable low during startup or fault
// - stack enabled only when all ready
// - primary clamps comp while enable low
// - drive power good low during init
// - secondary releases power good after init
// - primary raises power good after ramp
// - secondary leaves discontinuous on good rise
// - current limit local, others stack wide
// - secondaries force pwm, primary configured
// - chain phase offset about 120 degrees
// - only primary uses configuration bus
// - only primary reads voltage select pins
// - secondary discharge always enabled
// - voltage scaling only through primary
// - spread spectrum only from primary chain
// - external sync only to primary
// - disabling re-presets discontinuous allowance
// - thermal pulls enable unless single set
module scc_stack_ctrl
    import scc_pkg::*;
#(
    parameter int INIT_CYCLES = SCC_INIT_CYCLES,
    parameter int RAMP_CYCLES = SCC_RAMP_CYCLES
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // role strap and chained clock
    input  wire logic       chain_clock_out_pin_i,
    output logic            chain_clock_out_pin_o,
    output logic            chain_clock_out_pin_oe_o,
    input  wire logic       mode_sync_pin_i,
    // shared enable line
    input  wire logic       enable_line_i,
    output logic            enable_line_o,
    output logic            enable_line_oe_o,
    // shared power good line
    input  wire logic       power_good_line_i,
    output logic            power_good_line_o,
    output logic            power_good_line_oe_o,
    // compensation clamp
    output logic            comp_clamp_o,
    output logic            comp_drive_o,
    // local faults and status
    input  wire logic       thermal_shutdown_i,
    input  wire logic       undervoltage_lockout_i,
    input  wire logic       overvoltage_lockout_i,
    input  wire logic       current_limit_i,
    input  wire logic       vout_in_window_i,
    input  wire logic       single_cfg_i,
    input  wire logic       switch_enable_i,
    // settings from the configuration bus and the voltage select pins
    input  wire logic       bus_forced_pwm_i,
    input  wire logic       bus_discharge_en_i,
    input  wire logic       bus_dvs_req_i,
    input  wire logic       bus_ssc_en_i,
    input  wire logic       bus_ext_sync_en_i,
    input  wire logic       voltage_select_pin_a_i,
    input  wire logic       voltage_select_pin_b_i,
    // results
    output logic            role_secondary_o,
    output logic            bus_active_o,
    output logic [1:0]      vsel_o,
    output logic            forced_pwm_o,
    output logic            discharge_en_o,
    output logic            dvs_allowed_o,
    output logic            ssc_active_o,
    output logic            continuous_conduction_o,
    output logic            switching_o,
    output logic            error_amp_clamp_o
);

    initial begin
        if (INIT_CYCLES < 1 || RAMP_CYCLES < 1 || INIT_CYCLES > 65535 || RAMP_CYCLES > 65535) begin
            $error("counts out of range");
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    wire  logic [7:0] raw = {voltage_select_pin_b_i, voltage_select_pin_a_i, mode_sync_pin_i,
                             vout_in_window_i, power_good_line_i, enable_line_i,
                             chain_clock_out_pin_i, single_cfg_i};

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    wire logic single_s = s2_q[0];
    wire logic strap_s  = s2_q[1];
    wire logic en_s     = s2_q[2];
    wire logic pg_s     = s2_q[3];
    wire logic win_s    = s2_q[4];
    wire logic sync_s   = s2_q[5];
    wire logic [1:0] vsel_pins_s = s2_q[7:6];

    // ****************************************
    // state and counters
    // ****************************************
    scc_state_t  st_q;
    scc_state_t  st_d;
    logic [15:0] cnt_q;
    logic        role_q;
    logic [1:0]  vsel_q;
    logic        pg_q;
    logic        ff_ccm_q;
    logic        ff_pull_q;

    // faults that must stop the whole stack; current limit stays local
    wire logic stack_fault = undervoltage_lockout_i | overvoltage_lockout_i
                           | (thermal_shutdown_i & ~single_s);
    wire logic disabled    = ~en_s | ~switch_enable_i | thermal_shutdown_i
                           | undervoltage_lockout_i | overvoltage_lockout_i;
    wire logic init_done   = (cnt_q == 16'(INIT_CYCLES - 1));
    wire logic ramp_done   = (cnt_q == 16'(RAMP_CYCLES - 1));
    wire logic pg_rise     = pg_s & ~pg_q;
    wire logic in_init     = (st_q == SCC_ST_INIT);

    always_comb begin
        st_d = st_q;
        case (st_q)
            SCC_ST_INIT: begin
                if (init_done) begin
                    st_d = SCC_ST_WAIT_EN;
                end
            end
            SCC_ST_WAIT_EN: begin
                if (stack_fault) begin
                    st_d = SCC_ST_FAULT;
                end else if (~disabled) begin
                    st_d = SCC_ST_RAMP;
                end
            end
            SCC_ST_RAMP: begin
                if (stack_fault) begin
                    st_d = SCC_ST_FAULT;
                end else if (disabled) begin
                    st_d = SCC_ST_WAIT_EN;
                end else if (ramp_done) begin
                    st_d = SCC_ST_RUN;
                end
            end
            SCC_ST_RUN: begin
                if (stack_fault) begin
                    st_d = SCC_ST_FAULT;
                end else if (disabled) begin
                    st_d = SCC_ST_WAIT_EN;
                end
            end
            SCC_ST_FAULT: begin
                if (~stack_fault) begin
                    st_d = SCC_ST_WAIT_EN;                                    // new soft start
                end
            end
            default: st_d = SCC_ST_INIT;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q  <= SCC_ST_INIT;
            cnt_q <= 16'h0000;
        end else begin
            st_q  <= st_d;
            cnt_q <= (st_d != st_q) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // ****************************************
    // role strap and voltage select capture
    // ****************************************
    // strap is read on the last init cycle, after the synchronisers settled
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            role_q <= SCC_ROLE_RST;
            vsel_q <= SCC_VSEL_RST;
        end else if (in_init && init_done) begin
            role_q <= (strap_s == SCC_STRAP_SECOND);
            vsel_q <= (strap_s == SCC_STRAP_SECOND) ? SCC_VSEL_RST : vsel_pins_s;
        end
    end

    // ****************************************
    // secondary conduction latches
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pg_q      <= 1'b0;
            ff_ccm_q  <= 1'b0;
            ff_pull_q <= 1'b1;
        end else begin
            pg_q      <= pg_s;
            // pulldown follows init alone, so release never waits on enable
            ff_pull_q <= in_init;
            if (in_init || disabled) begin
                ff_ccm_q  <= 1'b0;
            end else if (pg_rise) begin
                ff_ccm_q  <= 1'b1;
            end
        end
    end

    // ****************************************
    // shared lines
    // ****************************************
    wire logic running     = (st_q == SCC_ST_RUN);
    wire logic pull_en     = in_init | (st_q == SCC_ST_FAULT) | stack_fault;
    wire logic pg_release  = role_q ? ~ff_pull_q
                                    : (running & win_s & ~disabled);

    // open drain: only ever drive low, the pullup makes the wired-and
    assign enable_line_o         = 1'b0;
    assign enable_line_oe_o      = pull_en;
    assign power_good_line_o     = 1'b0;
    assign power_good_line_oe_o  = ~pg_release;

    assign comp_clamp_o = ~role_q & ~en_s;
    assign comp_drive_o = ~role_q & en_s & ~in_init;

    // ****************************************
    // feature gating by role
    // ****************************************
    scc_phase_if ph();
    assign ph.tick = sync_s;

    scc_phase_gen #(
        .PERIOD    (SCC_PERIOD_DIV)
    ) u_phase (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .ref_clk_i (sync_s),
        .ref_sel_i (role_q | bus_ext_sync_en_i),
        .ph        (ph)
    );

    logic chain_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chain_q <= 1'b0;
        end else if (ph.phase_pulse) begin
            chain_q <= ~chain_q;
        end
    end

    // strap pin is only an input until the role is known
    assign chain_clock_out_pin_o    = chain_q;
    assign chain_clock_out_pin_oe_o = ~in_init;

    assign role_secondary_o        = role_q;
    assign bus_active_o            = ~role_q;
    assign vsel_o                  = vsel_q;
    assign forced_pwm_o            = role_q | bus_forced_pwm_i;
    assign discharge_en_o          = role_q | bus_discharge_en_i;
    assign dvs_allowed_o           = ~role_q & bus_dvs_req_i;
    assign ssc_active_o            = ~role_q & bus_ssc_en_i;
    assign continuous_conduction_o = role_q ? ff_ccm_q : forced_pwm_o;
    assign switching_o             = (st_q == SCC_ST_RAMP) | running;
    assign error_amp_clamp_o       = current_limit_i & switching_o;

    // ****************************************
    // checks
    // ****************************************
    property p_init_pulls;
        @(posedge sys_clk_i) disable iff (rst_i)
        in_init |-> (enable_line_oe_o && power_good_line_oe_o);
    endproperty
    a_init_pulls: assert property (p_init_pulls) else $error("init not pulling");

    property p_fault_pulls;
        @(posedge sys_clk_i) disable iff (rst_i)
        (undervoltage_lockout_i || overvoltage_lockout_i) |-> enable_line_oe_o;
    endproperty
    a_fault_pulls: assert property (p_fault_pulls) else $error("fault no pull");

    property p_single_therm;
        @(posedge sys_clk_i) disable iff (rst_i)
        (thermal_shutdown_i && single_s && running) |=> !switching_o;
    endproperty
    a_single_therm: assert property (p_single_therm) else $error("thermal ignored");

    property p_sec_pg;
        @(posedge sys_clk_i) disable iff (rst_i)
        (role_q && !in_init && !disabled) |-> !power_good_line_oe_o;
    endproperty
    a_sec_pg: assert property (p_sec_pg) else $error("secondary holds pg");

    property p_prim_pg;
        @(posedge sys_clk_i) disable iff (rst_i)
        (!role_q && !power_good_line_oe_o) |-> running;
    endproperty
    a_prim_pg: assert property (p_prim_pg) else $error("pg early");

    property p_ccm;
        @(posedge sys_clk_i) disable iff (rst_i)
        (role_q && pg_rise && !disabled && !in_init) |=> continuous_conduction_o;
    endproperty
    a_ccm: assert property (p_ccm) else $error("no ccm");

    property p_dcm_reset;
        @(posedge sys_clk_i) disable iff (rst_i)
        (role_q && disabled) |=> !continuous_conduction_o;
    endproperty
    a_dcm_reset: assert property (p_dcm_reset) else $error("dcm not re-allowed");

    property p_comp;
        @(posedge sys_clk_i) disable iff (rst_i)
        (!role_q && !en_s) |-> (comp_clamp_o && !comp_drive_o);
    endproperty
    a_comp: assert property (p_comp) else $error("comp not held");

    property p_sec_feat;
        @(posedge sys_clk_i) disable iff (rst_i)
        role_q |-> (discharge_en_o && forced_pwm_o && !dvs_allowed_o && !ssc_active_o);
    endproperty
    a_sec_feat: assert property (p_sec_feat) else $error("role gating");

    property p_ramp_gate;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(switching_o) |-> $past(en_s);
    endproperty
    a_ramp_gate: assert property (p_ramp_gate) else $error("start without enable");

    property p_strap_role;
        @(posedge sys_clk_i) disable iff (rst_i)
        (in_init && init_done && (strap_s == SCC_STRAP_SECOND)) |=> role_secondary_o;
    endproperty
    a_strap_role: assert property (p_strap_role) else $error("strap not taken");

    c_secondary: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(role_q));
    c_run:       cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(running));
    c_ccm:       cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(ff_ccm_q));
    c_fault:     cover property (@(posedge sys_clk_i) disable iff (rst_i) st_q == SCC_ST_FAULT);
    c_single:    cover property (@(posedge sys_clk_i) disable iff (rst_i)
        thermal_shutdown_i && single_s && !enable_line_oe_o);

endmodule

/* File: scc_stack_peer.sv */
`timescale 1ns/1ps
module scc_stack_peer #(
    parameter int INIT = 40,
    parameter int RAMP = 12
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // role and commanded fault
    input  wire logic role_primary_i,
    input  wire logic fault_i,
    // shared lines
    input  wire logic enable_line_i,
    output logic      en_pull_o,
    output logic      pg_pull_o,
    output logic      sync_o
);
    int   init_q;
    int   ramp_q;
    int   div_q;
    logic init_busy;
    // no hiccup protection exists in this stack model
    assign init_busy = init_q < INIT;
    assign en_pull_o = init_busy | fault_i;
    assign pg_pull_o = init_busy | (role_primary_i & (ramp_q < RAMP));
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_q <= 0;
            ramp_q <= 0;
            div_q <= 0;
            sync_o <= 1'b0;
        end else begin
            if (init_busy) begin
                init_q <= init_q + 1;
            end
            // ramp restarts whenever the stack is disabled
            ramp_q <= !enable_line_i ? 0 : ((ramp_q < RAMP) ? ramp_q + 1 : ramp_q);
            // chained clock stands still while the stack is disabled
            if (role_primary_i && enable_line_i) begin
                div_q <= (div_q == 8) ? 0 : div_q + 1;
                if (div_q == 8) begin
                    sync_o <= ~sync_o;
                end
            end
        end
    end
endmodule

/* File: test_stacked_converter_coordination.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s expected %b seen %b", nm, e, g); end end
module test_stacked_converter_coordination;
    import scc_pkg::*;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    localparam int INIT = 20;
    localparam int RAMP = 8;
    localparam int I_ROLE = 0, I_BUS = 1, I_ENOE = 2, I_PGOE = 3, I_CLMP = 4, I_FPWM = 5;
    localparam int I_DIS = 6, I_DVS = 7, I_SSC = 8, I_CCM = 9, I_EAC = 10, I_SW = 11;
    localparam int I_VA = 12, I_VB = 13, I_DRV = 14, I_CHOE = 15;
    typedef struct {int idx; logic val;} scc_note_t;
    string names [16] = '{"role", "bus", "en_oe", "pg_oe", "clamp", "fpwm", "disch", "dvs",
                          "ssc", "ccm", "ea_clamp", "switching", "vsel_a", "vsel_b",
                          "comp_drive", "chain_oe"};
    scc_note_t exp_q[$];
    event      obs_ev;
    int        fail_count = 0;
    int        cmp_count = 0;
    int        i;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, strap = 1'b1, peer_primary = 1'b0, peer_fault = 1'b0;
    logic thermal = 1'b0, undervoltage_lockout = 1'b0, overvoltage_lockout = 1'b0, ilim = 1'b0, win = 1'b0, single = 1'b0;
    logic swen = 1'b1, fpwm = 1'b0, dis = 1'b0, dynamic_voltage_scaling = 1'b0, spread_spectrum_clocking = 1'b0, ext = 1'b0;
    logic va = 1'b0, vb = 1'b0;
    logic chain_o, chain_oe, en_o, en_oe, pg_o, pg_oe, clamp, cdrive, role, bus, fpwm_o;
    logic dis_o, dvs_o, ssc_o, continuous_conduction, sw, eac, peer_en, peer_pg, peer_sync;
    logic [1:0]  vsel;
    logic [15:0] obs;
    wire         chain_pin = chain_oe ? chain_o : strap;
    wire         en_line = (en_oe ? en_o : 1'b1) & ~peer_en;
    wire         pg_line = (pg_oe ? pg_o : 1'b1) & ~peer_pg;
    assign obs = {chain_oe, cdrive, vsel[1], vsel[0], sw, eac, continuous_conduction, ssc_o, dvs_o, dis_o, fpwm_o,
                  clamp, pg_oe,
                  en_oe, bus, role};
    always #12.5 sys_clk_i = ~sys_clk_i;

    scc_stack_ctrl #(.INIT_CYCLES(INIT), .RAMP_CYCLES(RAMP)) uut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .chain_clock_out_pin_i(chain_pin),
        .chain_clock_out_pin_o(chain_o), .chain_clock_out_pin_oe_o(chain_oe),
        .mode_sync_pin_i(peer_sync), .enable_line_i(en_line), .enable_line_o(en_o),
        .enable_line_oe_o(en_oe), .power_good_line_i(pg_line), .power_good_line_o(pg_o),
        .power_good_line_oe_o(pg_oe), .comp_clamp_o(clamp), .comp_drive_o(cdrive),
        .thermal_shutdown_i(thermal), .undervoltage_lockout_i(undervoltage_lockout),
        .overvoltage_lockout_i(overvoltage_lockout), .current_limit_i(ilim), .vout_in_window_i(win),
        .single_cfg_i(single), .switch_enable_i(swen), .bus_forced_pwm_i(fpwm),
        .bus_discharge_en_i(dis), .bus_dvs_req_i(dynamic_voltage_scaling), .bus_ssc_en_i(spread_spectrum_clocking),
        .bus_ext_sync_en_i(ext), .voltage_select_pin_a_i(va), .voltage_select_pin_b_i(vb),
        .role_secondary_o(role), .bus_active_o(bus), .vsel_o(vsel), .forced_pwm_o(fpwm_o),
        .discharge_en_o(dis_o), .dvs_allowed_o(dvs_o), .ssc_active_o(ssc_o),
        .continuous_conduction_o(continuous_conduction), .switching_o(sw), .error_amp_clamp_o(eac));

    scc_stack_peer #(.INIT(40), .RAMP(12)) peer (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .role_primary_i(peer_primary),
        .fault_i(peer_fault), .enable_line_i(en_line), .en_pull_o(peer_en),
        .pg_pull_o(peer_pg), .sync_o(peer_sync));

    // ****************************************
    // tasks
    // ****************************************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // the short delay lets the monitor drain the note before time moves on
    task automatic note(input int idx, input logic val);
        exp_q.push_back('{idx, val});
        ->obs_ev;
        #0.1;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wait_for(input int idx, input logic val, input int lim);
        for (int k = 0; k < lim && obs[idx] !== val; k++) @(negedge sys_clk_i);
        note(idx, val);
    endtask
    task automatic restart(input logic strap_lvl);
        rst_i = 1'b1;
        strap = strap_lvl;
        peer_primary = ~strap_lvl;
        cycles(12);
        rst_i = 1'b0;
    endtask

    // ****************************************
    // monitor, watchdog and sequence
    // ****************************************
    initial begin
        scc_note_t n;
        forever begin
            @(obs_ev);
            while (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                `CHK(names[n.idx], n.val, obs[n.idx])
            end
        end
    end
    initial begin
        #(4000 * 25);
        fail_count++;
        complete_run();
    end
    initial begin
        void'($urandom(66938));
        {va, vb, fpwm, dis, dynamic_voltage_scaling, spread_spectrum_clocking, ext} = 7'($urandom);
        fpwm = 1'b1;
        restart(1'b1);
        cycles(5);
        note(I_CHOE, 1'b0);
        note(I_ENOE, 1'b1);
        note(I_PGOE, 1'b1);
        cycles(INIT);
        note(I_ROLE, 1'b0);
        note(I_BUS, 1'b1);
        note(I_VA, va);
        note(I_VB, vb);
        note(I_ENOE, 1'b0);
        note(I_CLMP, 1'b1);
        note(I_DRV, 1'b0);
        note(I_CHOE, 1'b1);
        note(I_SW, 1'b0);
        note(I_FPWM, fpwm);
        note(I_DIS, dis);
        note(I_DVS, dynamic_voltage_scaling);
        note(I_SSC, spread_spectrum_clocking);
        wait_for(I_SW, 1'b1, 60);
        note(I_CLMP, 1'b0);
        note(I_DRV, 1'b1);
        note(I_PGOE, 1'b1);
        win = 1'b1;
        wait_for(I_PGOE, 1'b0, RAMP + 10);
        peer_fault = 1'b1;
        cycles(4);
        note(I_SW, 1'b0);
        note(I_CLMP, 1'b1);
        peer_fault = 1'b0;
        wait_for(I_SW, 1'b1, 60);
        ilim = 1'b1;
        cycles(3);
        note(I_EAC, 1'b1);
        note(I_ENOE, 1'b0);
        note(I_SW, 1'b1);
        ilim = 1'b0;
        for (i = 0; i < 4; i++) begin
            single = (i == 3);
            cycles(3);
            {thermal, undervoltage_lockout, overvoltage_lockout} = (i == 3) ? 3'h4 : 3'h1 << i;
            cycles(4);
            note(I_ENOE, i != 3);
            note(I_SW, 1'b0);
            note(I_PGOE, 1'b1);
            {thermal, undervoltage_lockout, overvoltage_lockout} = 3'h0;
            wait_for(I_SW, 1'b1, 100);
        end
        single = 1'b0;
        restart(1'b0);
        {fpwm, dis, dynamic_voltage_scaling, spread_spectrum_clocking, va, vb} = 6'h0F;
        cycles(INIT + 4);
        note(I_ROLE, 1'b1);
        note(I_BUS, 1'b0);
        note(I_DRV, 1'b0);
        note(I_VA, 1'b0);
        note(I_VB, 1'b0);
        note(I_FPWM, 1'b1);
        note(I_DIS, 1'b1);
        note(I_DVS, 1'b0);
        note(I_SSC, 1'b0);
        note(I_PGOE, 1'b0);
        note(I_CCM, 1'b0);
        wait_for(I_CCM, 1'b1, 80);
        thermal = 1'b1;
        cycles(4);
        note(I_CCM, 1'b0);
        note(I_ENOE, 1'b1);
        thermal = 1'b0;
        wait_for(I_CCM, 1'b1, 150);
        complete_run();
    end
endmodule
